/* core/irq_defs.svh */
// Register offsets, field positions and masks of the interrupt arbiter.
// Assumes a 16-bit peripheral port with word offsets.
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH
`define OFF_PRIO0 5'h00
`define OFF_PRIO1 5'h01
`define OFF_PRIO6 5'h06
`define OFF_VEC_BASE 5'h07
`define OFF_FM0 5'h08
`define OFF_FVL0 5'h09
`define OFF_FVH0 5'h0A
`define OFF_FM1 5'h0B
`define OFF_FVL1 5'h0C
`define OFF_FVH1 5'h0D
`define OFF_PEND0 5'h0E
`define OFF_PEND1 5'h0F
`define OFF_PEND2 5'h10
`define OFF_PEND3 5'h11
`define OFF_CTRL 5'h16
`define WORD_RST 16'h0000
`define WMASK_PRIO0 16'hF3FF
`define WMASK_PRIO1 16'hC03F
`define WMASK_CTRL 16'h0020
`define WMASK_ALL 16'hFFFF
`define CTRL_OFF_BIT 5
`define LEVEL_VIEW_LSB 0
`define LSB_CLOCK_SYNTH 14
`define LSB_LOW_VOLTAGE 12
`define LSB_DEBUG_RX 8
`define LSB_DEBUG_TX 6
`define LSB_DEBUG_TRACE 4
`define LSB_DEBUG_BREAK 2
`define LSB_DEBUG_STEP 0
`define LSB_PORT_D 14
`define LSB_FLASH_EMPTY 4
`define LSB_FLASH_DONE 2
`define LSB_FLASH_ERR 0
`define NUM_SRC 64
`define NUM_FIELD_SRC 56
`define FAST_LEVEL 2'h2
`define CODE_OFF 2'h0
`endif

/* core/irq_pkg.sv */
// Types shared by the interrupt arbiter.
// Assumes irq_defs.svh supplies the numeric constants.
package irq_pkg;
    typedef logic [1:0] level_t;
    typedef logic [5:0] src_t;
    typedef logic [15:0] word_t;
    typedef logic [4:0] offset_t;
endpackage : irq_pkg

/* core/interrupt_arbiter.sv */
// Interrupt arbiter: priority registers, vector base, fast vectors,
// pending view and control, plus the level/number arbitration.
// Assumes requests and bus come from logic on clk; core samples outputs.
//
// Operation
// - Priority registers 0-6, vector base 7, fast match/address 8-D decoded.
// - Pending registers E-11 and control 16 decoded; gaps read zero.
// - Register 0 bits 15-14: clock synth source, codes 01-11 give levels 1-3.
// - Register 0 bits 13-12: low voltage source, levels 1-3.
// - Register 0 bits 9-8: debug receive full source, levels 1-3.
// - Register 0 bits 7-6: debug transmit empty source, levels 1-3.
// - Register 0 bits 5-4: debug trace source, levels 1-3.
// - Register 0 bits 3-2: debug breakpoint source, levels 1-3.
// - Register 0 bits 1-0: debug step source, levels 1-3.
// - Register 1 bits 15-14: port D source, codes 01-11 give levels 0-2.
// - Priority registers 0 and 1 reset to zero, all sources off.
// - Register 1 bits 5-4, 3-2, 1-0: flash sources, levels 0-2.
// - Same level ties go to the lowest source number.
// - Normal vector address is vector base joined with source number.
// - Level 2 winner matching a fast match register uses its address pair.
`timescale 1ns/10ps
`include "irq_defs.svh"

module interrupt_arbiter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Peripheral register port
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire irq_pkg::offset_t bus_addr,
    input wire irq_pkg::word_t bus_wdata,
    output irq_pkg::word_t bus_rdata,
    // Request lines, one per source
    input wire logic [63:0] irq_req,
    // Core side
    output logic irq_pending,
    output irq_pkg::level_t irq_level,
    output irq_pkg::src_t irq_vector,
    output logic irq_fast,
    output logic [31:0] vector_addr
);

    logic [6:0][15:0] prio;
    irq_pkg::word_t vec_base;
    logic [1:0][15:0] fmatch;
    logic [1:0][15:0] fvlow;
    logic [1:0][15:0] fvhigh;
    logic glob_off;
    logic [1:0] level_view;
    logic wr;
    irq_pkg::word_t next_rdata;
    logic best_ok;
    irq_pkg::level_t best_lvl;
    irq_pkg::src_t best_src;
    logic hit0;
    logic hit1;
    logic beaten;

    // Writable bits per offset; reserved bits never store
    function automatic irq_pkg::word_t wmask(input irq_pkg::offset_t a);
        case (a)
            `OFF_PRIO0: wmask = `WMASK_PRIO0;
            `OFF_PRIO1: wmask = `WMASK_PRIO1;
            `OFF_CTRL: wmask = `WMASK_CTRL;
            default: wmask = `WMASK_ALL;
        endcase
    endfunction : wmask

    // Priority code of a source; sources past the field range have none
    function automatic logic [1:0] code_of(input logic [6:0][15:0] p, input irq_pkg::src_t s);
        logic [3:0] hi;
        hi = {~s[2:0], 1'b1};
        case (s)
            6'h00: code_of = p[0][`LSB_CLOCK_SYNTH +: 2];
            6'h01: code_of = p[0][`LSB_LOW_VOLTAGE +: 2];
            6'h03: code_of = p[0][`LSB_DEBUG_RX +: 2];
            6'h04: code_of = p[0][`LSB_DEBUG_TX +: 2];
            6'h05: code_of = p[0][`LSB_DEBUG_TRACE +: 2];
            6'h06: code_of = p[0][`LSB_DEBUG_BREAK +: 2];
            6'h07: code_of = p[0][`LSB_DEBUG_STEP +: 2];
            6'h08: code_of = p[1][`LSB_PORT_D +: 2];
            6'h0D: code_of = p[1][`LSB_FLASH_EMPTY +: 2];
            6'h0E: code_of = p[1][`LSB_FLASH_DONE +: 2];
            6'h0F: code_of = p[1][`LSB_FLASH_ERR +: 2];
            default: begin
                if (s < 6'(`NUM_FIELD_SRC))
                    code_of = p[s[5:3]][hi -: 2];
                else
                    code_of = `CODE_OFF;
            end
        endcase
    endfunction : code_of

    // Register 0 sources run levels 1-3, all others 0-2
    function automatic irq_pkg::level_t level_of(input irq_pkg::src_t s, input logic [1:0] c);
        if (s[5:3] == 3'h0)
            level_of = c;
        else
            level_of = c - 2'h1;
    endfunction : level_of

    assign wr = bus_sel && bus_wr;

    // Priority registers; writes land at once so arbitration sees them next cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prio <= '0;
        end else if (wr && bus_addr <= `OFF_PRIO6) begin
            prio[bus_addr[2:0]] <= bus_wdata & wmask(bus_addr);
        end
    end

    // Vector base and fast vector registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vec_base <= `WORD_RST;
            fmatch <= '0;
            fvlow <= '0;
            fvhigh <= '0;
        end else if (wr) begin
            case (bus_addr)
                `OFF_VEC_BASE: vec_base <= bus_wdata;
                `OFF_FM0: fmatch[0] <= bus_wdata;
                `OFF_FVL0: fvlow[0] <= bus_wdata;
                `OFF_FVH0: fvhigh[0] <= bus_wdata;
                `OFF_FM1: fmatch[1] <= bus_wdata;
                `OFF_FVL1: fvlow[1] <= bus_wdata;
                `OFF_FVH1: fvhigh[1] <= bus_wdata;
                default: ;
            endcase
        end
    end

    // Control: global off bit only; the level view is read-only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            glob_off <= 1'b0;
        end else if (wr && bus_addr == `OFF_CTRL) begin
            glob_off <= bus_wdata[`CTRL_OFF_BIT];
        end
    end

    // Read mux; unmapped and reserved offsets read zero
    always_comb begin
        next_rdata = `WORD_RST;
        case (bus_addr)
            `OFF_VEC_BASE: next_rdata = vec_base;
            `OFF_FM0: next_rdata = fmatch[0];
            `OFF_FVL0: next_rdata = fvlow[0];
            `OFF_FVH0: next_rdata = fvhigh[0];
            `OFF_FM1: next_rdata = fmatch[1];
            `OFF_FVL1: next_rdata = fvlow[1];
            `OFF_FVH1: next_rdata = fvhigh[1];
            `OFF_PEND0: next_rdata = irq_req[15:0];
            `OFF_PEND1: next_rdata = irq_req[31:16];
            `OFF_PEND2: next_rdata = irq_req[47:32];
            `OFF_PEND3: next_rdata = irq_req[63:48];
            `OFF_CTRL: begin
                next_rdata[`CTRL_OFF_BIT] = glob_off;
                next_rdata[`LEVEL_VIEW_LSB +: 2] = level_view;
            end
            default: begin
                if (bus_addr <= `OFF_PRIO6)
                    next_rdata = prio[bus_addr[2:0]];
            end
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            bus_rdata <= `WORD_RST;
        else if (bus_sel && bus_rd)
            bus_rdata <= next_rdata;
    end

    // Arbitration; scanning downward with >= leaves the lowest number on ties
    always_comb begin
        logic [1:0] c;
        irq_pkg::level_t l;
        c = `CODE_OFF;
        l = 2'h0;
        best_ok = 1'b0;
        best_lvl = 2'h0;
        best_src = 6'h00;
        for (int i = `NUM_SRC - 1; i >= 0; i--) begin
            c = code_of(prio, 6'(i));
            l = level_of(6'(i), c);
            if (irq_req[i] && c != `CODE_OFF && !glob_off) begin
                if (!best_ok || l >= best_lvl) begin
                    best_ok = 1'b1;
                    best_lvl = l;
                    best_src = 6'(i);
                end
            end
        end
    end

    // Fast match only for a level 2 winner; slot 0 wins if both match
    assign hit0 = best_ok && best_lvl == `FAST_LEVEL && fmatch[0] == 16'(best_src);
    assign hit1 = best_ok && best_lvl == `FAST_LEVEL && fmatch[1] == 16'(best_src);

    // Core outputs, registered so the core sees a stable pair
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_pending <= 1'b0;
            irq_level <= 2'h0;
            irq_vector <= 6'h00;
            irq_fast <= 1'b0;
            vector_addr <= 32'h0000_0000;
        end else begin
            irq_pending <= best_ok;
            irq_level <= best_lvl;
            irq_vector <= best_src;
            irq_fast <= hit0 || hit1;
            if (hit0)
                vector_addr <= {fvhigh[0], fvlow[0]};
            else if (hit1)
                vector_addr <= {fvhigh[1], fvlow[1]};
            else
                vector_addr <= {10'h000, vec_base, best_src};
        end
    end

    // Level view for control reads: 00 none, then levels 0, 1, 2-or-3
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            level_view <= 2'h0;
        else if (!best_ok)
            level_view <= 2'h0;
        else if (best_lvl == 2'h3)
            level_view <= 2'h3;
        else
            level_view <= best_lvl + 2'h1;
    end

    // Helper for checks: any lower source active at the winning level
    always_comb begin
        beaten = 1'b0;
        for (int j = 0; j < `NUM_SRC; j++) begin
            if (6'(j) < best_src && irq_req[j] && !glob_off
                && code_of(prio, 6'(j)) != `CODE_OFF
                && level_of(6'(j), code_of(prio, 6'(j))) == best_lvl)
                beaten = 1'b1;
        end
    end

    sequence prio0_write;
        bus_sel && bus_wr && bus_addr == `OFF_PRIO0;
    endsequence

    sequence fast0_winner;
        hit0;
    endsequence

    sequence any_winner;
        best_ok;
    endsequence

    chk_reset_clear: assert property (@(posedge clk) $fell(rst) |-> prio[0] == '0 && prio[1] == '0)
        else $error("priority registers not clear after reset");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (prio[0] & ~`WMASK_PRIO0) == '0 && (prio[1] & ~`WMASK_PRIO1) == '0)
        else $error("reserved priority bits hold ones");
    chk_prio_write: assert property (@(posedge clk) disable iff (rst)
        prio0_write |=> prio[0] == ($past(bus_wdata) & `WMASK_PRIO0))
        else $error("priority write not stored next cycle");
    chk_no_disabled: assert property (@(posedge clk) disable iff (rst)
        best_ok |-> code_of(prio, best_src) != `CODE_OFF && irq_req[best_src])
        else $error("disabled source presented");
    chk_lowest_wins: assert property (@(posedge clk) disable iff (rst) best_ok |-> !beaten)
        else $error("higher numbered source won a tie");
    chk_vector_form: assert property (@(posedge clk) disable iff (rst)
        best_ok && !hit0 && !hit1 |=> vector_addr == {10'h000, $past(vec_base), $past(best_src)})
        else $error("normal vector address malformed");
    chk_fast_addr: assert property (@(posedge clk) disable iff (rst)
        fast0_winner |=> irq_fast && vector_addr == {$past(fvhigh[0]), $past(fvlow[0])})
        else $error("fast vector address not supplied");
    chk_level_range: assert property (@(posedge clk) disable iff (rst)
        best_ok && best_src == 6'h08 |-> best_lvl == prio[1][`LSB_PORT_D +: 2] - 2'h1)
        else $error("port D level mapping wrong");
    chk_pend_read: assert property (@(posedge clk) disable iff (rst)
        bus_sel && bus_rd && bus_addr == `OFF_PEND0 |=> bus_rdata == $past(irq_req[15:0]))
        else $error("pending register read wrong");
    chk_global_off: assert property (@(posedge clk) disable iff (rst) glob_off |=> !irq_pending)
        else $error("global off did not block requests");
    chk_winner_out: assert property (@(posedge clk) disable iff (rst)
        any_winner |=> irq_pending && irq_vector == $past(best_src) && irq_level == $past(best_lvl))
        else $error("winner not presented to core");
    chk_synth_level: assert property (@(posedge clk) disable iff (rst)
        best_ok && best_src == 6'h00 |-> best_lvl == prio[0][`LSB_CLOCK_SYNTH +: 2])
        else $error("clock synth level mapping wrong");
    chk_flash_level: assert property (@(posedge clk) disable iff (rst)
        best_ok && best_src == 6'h0F |-> best_lvl == prio[1][`LSB_FLASH_ERR +: 2] - 2'h1)
        else $error("flash error level mapping wrong");
    chk_view_idle: assert property (@(posedge clk) disable iff (rst) !best_ok |=> level_view == 2'h0)
        else $error("level view not cleared without winner");

endmodule : interrupt_arbiter

/* sim/core_model.sv */
// Core-side partner: takes the arbiter's offer when asked.
// Assumes the arbiter's core outputs are registered on clk.
`timescale 1ns/10ps
module core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Offer from the arbiter
    input wire logic irq_pending,
    input wire irq_pkg::level_t irq_level,
    input wire irq_pkg::src_t irq_vector,
    input wire logic irq_fast,
    input wire logic [31:0] vector_addr,
    // Sampling request and captured offer
    input wire logic sample,
    output logic got,
    output logic [41:0] seen
);
    // Offer taken as it stands; this core never acknowledges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            got <= 1'b0;
            seen <= 42'h0;
        end else begin
            got <= sample;
            if (sample) begin
                seen <= {irq_pending, irq_level, irq_vector, irq_fast, vector_addr};
            end
        end
    end
endmodule : core_model

/* sim/testbench.sv */
// Self-checking bench for the interrupt arbiter with a core model.
// Assumes irq_defs.svh and irq_pkg are compiled first.
`timescale 1ns/10ps
`include "irq_defs.svh"
module testbench;
    logic clk, rst, bus_sel, bus_wr, bus_rd, sample, got, rd_seen, off;
    logic irq_pending, irq_fast;
    irq_pkg::offset_t bus_addr;
    irq_pkg::word_t bus_wdata, bus_rdata;
    irq_pkg::level_t irq_level;
    irq_pkg::src_t irq_vector;
    logic [63:0] irq_req;
    logic [31:0] vector_addr;
    logic [41:0] seen;
    irq_pkg::word_t regs [0:13];
    irq_pkg::word_t q_rd [$];
    logic [83:0] q_core [$];
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    integer seed = 29;

    interrupt_arbiter interrupt_arbiter_i (.clk(clk), .rst(rst), .bus_sel(bus_sel), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .irq_req(irq_req), .irq_pending(irq_pending), .irq_level(irq_level), .irq_vector(irq_vector),
        .irq_fast(irq_fast), .vector_addr(vector_addr));
    core_model core_model_i (.clk(clk), .rst(rst), .irq_pending(irq_pending), .irq_level(irq_level),
        .irq_vector(irq_vector), .irq_fast(irq_fast), .vector_addr(vector_addr), .sample(sample),
        .got(got), .seen(seen));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic cmp_word(input irq_pkg::word_t g, input irq_pkg::word_t e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %0t read data %h expected %h", $time, g, e);
        end
    endtask : cmp_word

    // Masked compare: level and vector mean nothing without a winner
    task automatic cmp_core(input logic [41:0] g, input logic [83:0] em);
        n_checks++;
        if (((g ^ em[83:42]) & em[41:0]) !== 42'h0) begin
            n_fail++;
            $display("mismatch %0t core offer %h expected %h", $time, g, em[83:42]);
        end
    endtask : cmp_core

    // One-cycle write; mirror keeps only the bits the hardware stores
    task automatic wr(input irq_pkg::offset_t a, input irq_pkg::word_t d);
        @(posedge clk);
        bus_sel <= 1'b1;
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_sel <= 1'b0;
        bus_wr <= 1'b0;
        if (a <= 5'h0D) regs[a] = d & (a == `OFF_PRIO0 ? `WMASK_PRIO0 : a == `OFF_PRIO1 ? `WMASK_PRIO1 : `WMASK_ALL);
        if (a == `OFF_CTRL) off = d[`CTRL_OFF_BIT];
    endtask : wr

    task automatic rd(input irq_pkg::offset_t a, input irq_pkg::word_t e);
        @(posedge clk);
        bus_sel <= 1'b1;
        bus_rd <= 1'b1;
        bus_addr <= a;
        q_rd.push_back(e);
        @(posedge clk);
        bus_sel <= 1'b0;
        bus_rd <= 1'b0;
    endtask : rd

    // Predict the winner from the mirror, then have the core sample one cycle on
    task automatic check_core();
        int best, lv, l;
        logic [1:0] c;
        logic [41:0] e, m;
        best = -1;
        lv = -1;
        for (int s = 0; s < 16; s++) begin
            c = 2'(regs[s / 8] >> (2 * (7 - s % 8)));
            l = (s < 8) ? c : c - 1;
            if (c != 2'h0 && irq_req[s] && !off && l > lv) begin
                lv = l;
                best = s;
            end
        end
        m = (best < 0) ? {1'b1, 41'h0} : {42{1'b1}};
        e = 42'h0;
        if (best >= 0) begin
            e[41:32] = {1'b1, 2'(lv), 6'(best), lv == 2 && (regs[8] == best || regs[11] == best)};
            e[31:0] = !e[32] ? {10'h000, regs[7], 6'(best)} : regs[8] == best ? {regs[10], regs[9]} : {regs[13], regs[12]};
        end
        @(posedge clk);
        sample <= 1'b1;
        q_core.push_back({e, m});
        @(posedge clk);
        sample <= 1'b0;
    endtask : check_core

    // Monitor: read data lands one cycle after the strobe edge
    always @(posedge clk) rd_seen <= bus_sel && bus_rd;
    always @(negedge clk) begin
        if (rd_seen) cmp_word(bus_rdata, q_rd.pop_front());
        if (got) cmp_core(seen, q_core.pop_front());
    end

    // Hang guard, well above the few thousand cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        rst = 1'b1;
        bus_sel = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 5'h00;
        bus_wdata = 16'h0000;
        irq_req = {64{1'b1}};
        sample = 1'b0;
        off = 1'b0;
        foreach (regs[i]) regs[i] = 16'h0000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`OFF_PRIO0, `WORD_RST);
        rd(`OFF_PRIO1, `WORD_RST);
        check_core();
        wr(`OFF_PRIO0, 16'hFFFF);
        rd(`OFF_PRIO0, `WMASK_PRIO0);
        wr(`OFF_PRIO1, 16'hFFFF);
        rd(`OFF_PRIO1, `WMASK_PRIO1);
        for (int a = 2; a <= 13; a++) begin
            wr(5'(a), 16'($random(seed)));
            rd(5'(a), regs[a]);
        end
        for (int a = 2; a <= 6; a++) wr(5'(a), 16'h0000);
        irq_req <= {$random(seed), $random(seed)};
        @(posedge clk);
        for (int a = 0; a < 4; a++) rd(5'(14 + a), irq_req[16 * a +: 16]);
        rd(5'h12, 16'h0000);
        rd(5'h15, 16'h0000);
        check_core();
        // Random levels, requests and fast matches; reserved bits written zero
        for (int i = 0; i < 300; i++) begin
            wr(`OFF_FM0, 16'($random(seed)) & 16'h000F);
            wr(`OFF_FM1, 16'($random(seed)) & 16'h000F);
            wr(`OFF_PRIO0, 16'($random(seed)) & `WMASK_PRIO0);
            irq_req <= {$random(seed), $random(seed)};
            wr(`OFF_PRIO1, 16'($random(seed)) & `WMASK_PRIO1);
            check_core();
        end
        wr(`OFF_CTRL, `WMASK_CTRL);
        check_core();
        rd(`OFF_CTRL, `WMASK_CTRL);
        wr(`OFF_CTRL, 16'h0000);
        check_core();
        repeat (3) @(posedge clk);
        // Mid-run reset must drop the levels written above
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) regs[i] = 16'h0000;
        rd(`OFF_PRIO0, `WORD_RST);
        rd(`OFF_PRIO1, `WORD_RST);
        check_core();
        repeat (3) @(posedge clk);
        test_done();
    end
endmodule : testbench
